// ===== inc/sac_consts.svh
// Register map, field positions and reset values of the conversion control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ==========================================
// Register addresses
`define SAC_ADDR_CTRL 8'hAA
`define SAC_ADDR_CFG 8'hAB
`define SAC_ADDR_CHAN 8'hAC
`define SAC_ADDR_DATA 8'hAD
`define SAC_ADDR_PORTMODE 8'hAE

// ==========================================
// Reset values
`define SAC_CTRL_RST 8'h00
`define SAC_CFG_RST 8'hF8
`define SAC_CHAN_RST 3'h0
`define SAC_PORTMODE_RST 8'hFF
`define SAC_DATA_RST 8'h00

// ==========================================
// Control register fields
`define SAC_CTRL_EN 7
`define SAC_CTRL_TM 6
`define SAC_CTRL_INT 5
`define SAC_CTRL_BUSY 4
`define SAC_CTRL_CM_HI 3
`define SAC_CTRL_CM_LO 1

// ==========================================
// Configuration and channel fields
`define SAC_CFG_DIV_HI 7
`define SAC_CFG_DIV_LO 3
`define SAC_CFG_GAIN_HI 1
`define SAC_CFG_GAIN_LO 0
`define SAC_CHAN_HI 2

// ==========================================
// Sequencing constants
`define SAC_TRACK_LAST 2'h2
`define SAC_SAR_FIRST 8'h80
`define SAC_SAR_LAST 8'h01
`define SAC_DIV_ZERO 5'h00
`define SAC_BUSY_MAX 9'h160

`endif

// ===== inc/sac_pkg.sv
// Types shared by the conversion control modules
package sac_pkg;

  typedef enum logic [2:0] {
    SAC_SRC_BUSY = 3'b000,
    SAC_SRC_TMR3 = 3'b001,
    SAC_SRC_EXT = 3'b010,
    SAC_SRC_TMR2 = 3'b011
  } sac_src_t;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_TRACK = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;

endpackage : sac_pkg

// ===== inc/sac_conv_if.sv
// Control link between the register front end and the approximation engine
`timescale 1ns/1ns
interface sac_conv_if;
  logic start;
  logic abort;
  logic lowPowerTrack;
  logic [4:0] divisor;
  logic compIn;
  logic busy;
  logic tracking;
  logic convDone;
  logic [7:0] result;
  logic [7:0] trial;

  modport ctrl (
    output start,
    output abort,
    output lowPowerTrack,
    output divisor,
    output compIn,
    input busy,
    input tracking,
    input convDone,
    input result,
    input trial
  );

  modport core (
    input start,
    input abort,
    input lowPowerTrack,
    input divisor,
    input compIn,
    output busy,
    output tracking,
    output convDone,
    output result,
    output trial
  );
endinterface : sac_conv_if

// ===== rtl/sac_sar_core.sv
// Conversion clock divider, low-power tracking period and 8-bit approximation engine
`timescale 1ns/1ns
`include "sac_consts.svh"
module sac_sar_core (
  input wire logic clk,
  input wire logic rst_n,
  sac_conv_if.core cv
);
  sac_pkg::sac_state_t state_ff, nxt_state;
  logic [4:0] divCnt_ff;
  logic [1:0] phase_ff;
  logic [7:0] code_ff;
  logic [7:0] mask_ff;
  logic [7:0] result_ff;
  logic done_ff;
  wire active = (state_ff != sac_pkg::SAC_IDLE);
  wire sarTick = active && (divCnt_ff == cv.divisor); // RQ4
  wire lastBit = (mask_ff == `SAC_SAR_LAST);
  // Comparator high means the input is above the trial code, so the bit stays
  wire [7:0] keptCode = cv.compIn ? code_ff : (code_ff & ~mask_ff);
  wire [7:0] nxtMask = mask_ff >> 1;

  // ==========================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sac_pkg::SAC_IDLE: begin
        if (cv.start) begin
          nxt_state = cv.lowPowerTrack ? sac_pkg::SAC_TRACK : sac_pkg::SAC_CONV; // RQ13
        end
      end
      sac_pkg::SAC_TRACK: begin
        if (sarTick && phase_ff == `SAC_TRACK_LAST) begin
          nxt_state = sac_pkg::SAC_CONV; // RQ13
        end
      end
      sac_pkg::SAC_CONV: begin
        if (sarTick && lastBit) begin
          nxt_state = sac_pkg::SAC_IDLE;
        end
      end
      default: nxt_state = sac_pkg::SAC_IDLE;
    endcase
    if (cv.abort) begin
      nxt_state = sac_pkg::SAC_IDLE; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= sac_pkg::SAC_IDLE;
      divCnt_ff <= `SAC_DIV_ZERO;
      phase_ff <= 2'h0;
      code_ff <= `SAC_SAR_FIRST;
      mask_ff <= `SAC_SAR_FIRST;
      result_ff <= `SAC_DATA_RST;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      divCnt_ff <= (!active || sarTick) ? `SAC_DIV_ZERO : divCnt_ff + 5'h01; // RQ4
      done_ff <= !cv.abort && state_ff == sac_pkg::SAC_CONV && sarTick && lastBit;
      if (state_ff != sac_pkg::SAC_CONV) begin
        code_ff <= `SAC_SAR_FIRST;
        mask_ff <= `SAC_SAR_FIRST;
      end else if (sarTick) begin
        code_ff <= keptCode | nxtMask;
        mask_ff <= nxtMask;
        if (lastBit && !cv.abort) begin
          result_ff <= keptCode; // RQ10
        end
      end
      phase_ff <= (state_ff != sac_pkg::SAC_TRACK) ? 2'h0 : phase_ff + {1'b0, sarTick};
    end
  end

  assign cv.busy = active; // RQ8
  assign cv.tracking = (state_ff == sac_pkg::SAC_TRACK);
  assign cv.convDone = done_ff;
  assign cv.result = result_ff;
  assign cv.trial = code_ff;

  // ==========================================
  // Checks
  a_track_three_ticks: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    (state_ff == sac_pkg::SAC_TRACK && sarTick && phase_ff == `SAC_TRACK_LAST && !cv.abort)
      |=> state_ff == sac_pkg::SAC_CONV)
    else $error("tracking did not hand over after three conversion clocks");
  a_divider_gap: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    (sarTick && cv.divisor == 5'h03 && $stable(cv.divisor)) |=> !sarTick ##1 !sarTick ##1 (!sarTick || !active))
    else $error("conversion clock came early for divisor three");
endmodule : sac_sar_core

// ===== rtl/sac_top.sv
// Register front end, start selection and tracking control of the 8-bit converter
// Overview of operation
// RQ1 - Converter, hold and amplifier run only while the enable bit is one
// RQ2 - Eight input channels, chosen by the channel select register
// RQ3 - Gain field selects 0.5, 1, 2 or 4; reset gives 0.5
// RQ4 - Conversion clock is system clock divided by divisor field plus one
// RQ5 - Software keeps the conversion clock at or below 6 MHz
// RQ6 - Trigger sources never request more than 500 ksps
// RQ7 - One of five start sources starts a conversion, per start-mode field
// RQ8 - Busy bit reads one for the whole conversion, zero after
// RQ9 - Busy falling sets the done flag and, if enabled, an interrupt request
// RQ10 - The 8-bit result becomes readable in the data register on completion
// RQ11 - Software clears flag, writes busy, polls flag, then reads result
// RQ12 - Track mode zero tracks continuously except during a conversion
// RQ13 - Track mode one tracks three conversion clocks after a start, then converts
// RQ14 - Low-power with external start tracks while pin low, converts on rise
// RQ15 - Tracking can be shut off while the chip is in standby or sleep
// RQ16 - Pins with input-mode bit zero are analog and skipped by the crossbar
// RQ17 - Start codes: 000 busy, 001 timer3, 010 pin, 011 timer2, 1xx companion
// RQ18 - Hardware never clears the done flag; software writes zero
// RQ19 - Gain codes: 00 is 0.5, 01 is 1, 10 is 2, 11 is 4
// RQ20 - Starts arriving while tracking or converting are ignored
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "sac_consts.svh"
module sac_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic timer3Overflow,
  input wire logic timer2Overflow,
  input wire logic companionStartWrite,
  input wire logic extConvStartPin,
  input wire logic chipStandby,
  input wire logic comparatorOut,
  input wire logic irqEnable,
  output logic convIrq,
  output logic converterPowerOn,
  output logic trackEnable,
  output logic [2:0] muxChannel,
  output logic [1:0] gainSel,
  output logic [7:0] sarTrialCode,
  output logic [7:0] analogPinMask
);
  sac_conv_if cv ();

  logic [7:0] ctrl_ff;
  logic [7:0] cfg_ff;
  logic [2:0] chan_ff;
  logic [7:0] portMode_ff;
  logic doneFlag_ff, nxt_doneFlag;
  logic [7:0] rdData_ff, nxt_rdData;
  logic irq_ff;
  logic trackEn_ff, nxt_trackEn;
  logic pinS1_ff, pinS2_ff, pinS3_ff;
  logic pinStable_ff;

  // ==========================================
  // Address decode
  wire selCtrl = (regAddr == `SAC_ADDR_CTRL);
  wire selCfg = (regAddr == `SAC_ADDR_CFG);
  wire selChan = (regAddr == `SAC_ADDR_CHAN);
  wire selData = (regAddr == `SAC_ADDR_DATA);
  wire selPort = (regAddr == `SAC_ADDR_PORTMODE);
  wire wrCtrl = regWr && selCtrl;

  // ==========================================
  // Control fields
  wire enabled = ctrl_ff[`SAC_CTRL_EN];
  wire lowPowerMode = ctrl_ff[`SAC_CTRL_TM];
  wire [2:0] startMode = ctrl_ff[`SAC_CTRL_CM_HI:`SAC_CTRL_CM_LO];
  wire [2:0] wrStartMode = regWrData[`SAC_CTRL_CM_HI:`SAC_CTRL_CM_LO];
  wire extMode = (startMode == sac_pkg::SAC_SRC_EXT);

  // ==========================================
  // External start pin: three stages, a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinS1_ff <= 1'b0;
      pinS2_ff <= 1'b0;
      pinS3_ff <= 1'b0;
      pinStable_ff <= 1'b0;
    end else begin
      pinS1_ff <= extConvStartPin;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      if (pinS2_ff == pinS3_ff) begin
        pinStable_ff <= pinS3_ff;
      end
    end
  end
  wire pinRise = pinS2_ff && pinS3_ff && !pinStable_ff;

  // ==========================================
  // Start source selection
  // The busy-bit start follows the mode being written in the same cycle, so one write
  // can select software mode and start.
  wire softStart = wrCtrl && regWrData[`SAC_CTRL_BUSY] && regWrData[`SAC_CTRL_EN]
    && (wrStartMode == sac_pkg::SAC_SRC_BUSY); // RQ7 RQ17
  wire tmr3Start = (startMode == sac_pkg::SAC_SRC_TMR3) && timer3Overflow; // RQ17
  wire extStart = extMode && pinRise; // RQ17
  wire tmr2Start = (startMode == sac_pkg::SAC_SRC_TMR2) && timer2Overflow; // RQ17
  wire compStart = startMode[2] && companionStartWrite; // RQ17
  wire srcEvent = softStart || tmr3Start || extStart || tmr2Start || compStart; // RQ7
  // Starts during a running sequence are dropped so the active result is not corrupted
  wire startReq = enabled && !cv.busy && srcEvent; // RQ20 RQ1

  assign cv.start = startReq;
  assign cv.abort = !enabled; // RQ1
  // The pin's low phase already served as the tracking time in external low-power mode
  assign cv.lowPowerTrack = lowPowerMode && !extMode; // RQ13 RQ14
  assign cv.divisor = cfg_ff[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO]; // RQ4
  assign cv.compIn = comparatorOut;

  sac_sar_core uCore (
    .clk(clk),
    .rst_n(rst_n),
    .cv(cv)
  );

  // ==========================================
  // Done flag: hardware sets, only software clears; a set wins over a same-cycle clear
  always_comb begin
    nxt_doneFlag = doneFlag_ff;
    if (wrCtrl) begin
      nxt_doneFlag = regWrData[`SAC_CTRL_INT]; // RQ18
    end
    if (cv.convDone) begin
      nxt_doneFlag = 1'b1; // RQ9
    end
  end

  // ==========================================
  // Tracking control
  always_comb begin
    nxt_trackEn = 1'b0;
    if (enabled && !chipStandby) begin // RQ1 RQ15
      if (lowPowerMode) begin
        nxt_trackEn = cv.tracking || (extMode && !pinStable_ff && !cv.busy); // RQ13 RQ14
      end else begin
        nxt_trackEn = !cv.busy; // RQ12
      end
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    nxt_rdData = 8'h00;
    if (regRd) begin
      if (selCtrl) begin
        nxt_rdData = {ctrl_ff[7:6], doneFlag_ff, cv.busy, ctrl_ff[3:1], 1'b0}; // RQ8
      end else if (selCfg) begin
        nxt_rdData = {cfg_ff[7:3], 1'b0, cfg_ff[1:0]};
      end else if (selChan) begin
        nxt_rdData = {5'h00, chan_ff};
      end else if (selData) begin
        nxt_rdData = cv.result; // RQ10
      end else if (selPort) begin
        nxt_rdData = portMode_ff;
      end
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `SAC_CTRL_RST;
      cfg_ff <= `SAC_CFG_RST; // RQ3
      chan_ff <= `SAC_CHAN_RST;
      portMode_ff <= `SAC_PORTMODE_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_ff <= {regWrData[7:6], 2'b00, regWrData[3:1], 1'b0};
      end
      if (regWr && selCfg) begin
        cfg_ff <= {regWrData[7:3], 1'b0, regWrData[1:0]}; // RQ4 RQ19
      end
      if (regWr && selChan) begin
        chan_ff <= regWrData[`SAC_CHAN_HI:0]; // RQ2
      end
      if (regWr && selPort) begin
        portMode_ff <= regWrData; // RQ16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doneFlag_ff <= 1'b0;
      rdData_ff <= 8'h00;
      irq_ff <= 1'b0;
      trackEn_ff <= 1'b0;
    end else begin
      doneFlag_ff <= nxt_doneFlag;
      rdData_ff <= nxt_rdData;
      irq_ff <= cv.convDone && irqEnable; // RQ9
      trackEn_ff <= nxt_trackEn;
    end
  end

  // ==========================================
  // Outputs
  assign regRdData = rdData_ff;
  assign convIrq = irq_ff;
  assign converterPowerOn = enabled; // RQ1
  assign trackEnable = trackEn_ff;
  assign muxChannel = chan_ff; // RQ2
  assign gainSel = cfg_ff[`SAC_CFG_GAIN_HI:`SAC_CFG_GAIN_LO]; // RQ3 RQ19
  assign sarTrialCode = cv.trial;
  assign analogPinMask = ~portMode_ff; // RQ16

  // ==========================================
  // Busy length watch: eleven periods of the slowest conversion clock is the longest legal run
  logic [8:0] busyCnt_ff;
  always_ff @(posedge clk) begin
    if (!rst_n || !cv.busy) begin
      busyCnt_ff <= 9'h000;
    end else begin
      busyCnt_ff <= busyCnt_ff + 9'h001;
    end
  end

  // ==========================================
  // Checks
  a_done_sets_flag: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    cv.convDone |=> doneFlag_ff && $past(cv.busy, 2))
    else $error("done flag not set after conversion end");
  a_flag_stays_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    (doneFlag_ff && !wrCtrl) |=> doneFlag_ff)
    else $error("done flag cleared without a software write");
  a_irq_follows_done: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    (cv.convDone && irqEnable) |=> convIrq ##1 !convIrq)
    else $error("interrupt request missing or too long");
  a_no_restart: assert property (@(posedge clk) disable iff (!rst_n) // RQ20
    (cv.busy && srcEvent && enabled) |=> $stable(cv.trial) || cv.busy)
    else $error("start while busy disturbed the conversion");
  a_soft_start_busy: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    (softStart && enabled && !cv.busy) |=> cv.busy)
    else $error("busy-bit write did not start a conversion");
  a_shutdown_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    (!enabled) |=> !cv.busy ##0 !trackEnable)
    else $error("converter active while disabled");
  a_normal_track: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    (enabled && !lowPowerMode && !chipStandby) |=> trackEnable == !$past(cv.busy))
    else $error("normal tracking not continuous outside conversion");
  a_ext_lowpower: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
    (enabled && lowPowerMode && extMode && !cv.busy && !chipStandby && !pinStable_ff) |=> trackEnable)
    else $error("no tracking while start pin low");
  a_standby_off: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    chipStandby |=> !trackEnable)
    else $error("tracking during standby");
  a_lp_enters_track: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    (startReq && cv.lowPowerTrack) |=> cv.tracking [*2])
    else $error("low-power start skipped the tracking period");
  a_busy_bounded: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    busyCnt_ff < `SAC_BUSY_MAX)
    else $error("busy stood longer than the longest conversion");
  a_busy_fall_done: assert property (@(posedge clk) disable iff (!rst_n) // RQ8 RQ9
    ($fell(cv.busy) && $past(enabled)) |-> cv.convDone)
    else $error("busy fell without completing");
  a_done_after_busy: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    cv.convDone |-> (!cv.busy && $past(cv.busy)))
    else $error("completion without a falling busy");
  a_result_only_done: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    $changed(cv.result) |-> cv.convDone)
    else $error("result changed outside a completion");
  a_busy_readback: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    (regRd && selCtrl) |=> regRdData[`SAC_CTRL_BUSY] == $past(cv.busy))
    else $error("busy bit read back wrong");
  a_power_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    wrCtrl |=> converterPowerOn == $past(regWrData[`SAC_CTRL_EN]))
    else $error("enable write not applied");
  a_gain_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ3 RQ19
    (regWr && selCfg) |=> gainSel == $past(regWrData[`SAC_CFG_GAIN_HI:`SAC_CFG_GAIN_LO]))
    else $error("gain write not applied");
  a_channel_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    (regWr && selChan) |=> muxChannel == $past(regWrData[`SAC_CHAN_HI:0]))
    else $error("channel write not applied");
  a_pin_mask_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    (regWr && selPort) |=> analogPinMask == ~$past(regWrData))
    else $error("analog pin mask does not follow the input mode write");
  a_tmr3_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ17
    (enabled && !cv.busy && startMode == sac_pkg::SAC_SRC_TMR3 && timer3Overflow) |=> cv.busy)
    else $error("timer 3 overflow did not start");
  a_tmr2_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ17
    (enabled && !cv.busy && startMode == sac_pkg::SAC_SRC_TMR2 && timer2Overflow) |=> cv.busy)
    else $error("timer 2 overflow did not start");
  a_comp_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ17
    (enabled && !cv.busy && startMode[2] && companionStartWrite) |=> cv.busy)
    else $error("companion start did not start");
  a_pin_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ14 RQ17
    (enabled && !cv.busy && extMode && pinRise) |=> cv.busy && !cv.tracking)
    else $error("pin rise did not begin a conversion");
  a_idle_no_event: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ20
    (!cv.busy && !srcEvent) |=> !cv.busy)
    else $error("conversion began without a selected start event");
  a_lp_track_follow: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    (enabled && lowPowerMode && !extMode && !chipStandby) |=> trackEnable == $past(cv.tracking))
    else $error("low-power tracking outside the tracking period");
endmodule : sac_top

// ===== verification/sac_analog_model.sv
// Analog side model: eight input levels and the comparator feeding the approximation engine
`timescale 1ns/1ns
module sac_analog_model (
  input wire logic [2:0] muxChannel,
  input wire logic [7:0] sarTrialCode,
  output logic comparatorOut
);
  // Levels sit half a step above a code, so above and at-or-above never differ
  logic [8:0] level;
  assign level = {8'h11 + 8'h1F * {5'h00, muxChannel}, 1'b1};
  assign comparatorOut = level > {sarTrialCode, 1'b0};
endmodule : sac_analog_model

// ===== verification/tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`include "sac_consts.svh"
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic timer3Overflow = 1'b0;
  logic timer2Overflow = 1'b0;
  logic companionStartWrite = 1'b0;
  logic extConvStartPin = 1'b0;
  logic chipStandby = 1'b0;
  logic irqEnable = 1'b1;
  logic comparatorOut;
  logic [7:0] regRdData;
  logic convIrq;
  logic converterPowerOn;
  logic trackEnable;
  logic [2:0] muxChannel;
  logic [1:0] gainSel;
  logic [7:0] sarTrialCode;
  logic [7:0] analogPinMask;
  int err_count = 0;
  int checks = 0;
  int i;

  always #25 clk = ~clk;

  sac_top uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .timer3Overflow(timer3Overflow), .timer2Overflow(timer2Overflow),
    .companionStartWrite(companionStartWrite), .extConvStartPin(extConvStartPin), .chipStandby(chipStandby),
    .comparatorOut(comparatorOut), .irqEnable(irqEnable), .convIrq(convIrq), .converterPowerOn(converterPowerOn),
    .trackEnable(trackEnable), .muxChannel(muxChannel), .gainSel(gainSel), .sarTrialCode(sarTrialCode),
    .analogPinMask(analogPinMask));

  sac_analog_model analog (.muxChannel(muxChannel), .sarTrialCode(sarTrialCode), .comparatorOut(comparatorOut));

  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] expv, input logic [15:0] got);
    checks++;
    if (got !== expv) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, expv, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] expv, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(nm, {8'h00, expv}, {8'h00, regRdData});
  endtask : rd

  // ==========================================
  // Scenarios
  task automatic reset_and_regs();
    rd(`SAC_ADDR_CTRL, 8'h00, "ctrl_rst");
    rd(`SAC_ADDR_CFG, 8'hF8, "cfg_rst");
    rd(`SAC_ADDR_CHAN, 8'h00, "chan_rst");
    rd(`SAC_ADDR_DATA, 8'h00, "data_rst");
    rd(`SAC_ADDR_PORTMODE, 8'hFF, "port_rst");
    chk("power_rst", 16'h0000, {15'h0000, converterPowerOn});
    chk("trial_rst", 16'h0080, {8'h00, sarTrialCode});
    for (i = 0; i < 4; i++) begin
      wr(`SAC_ADDR_CFG, 8'h1C | i[7:0]);
      @(negedge clk);
      chk("gain", i[15:0], {14'h0000, gainSel});
    end
    rd(`SAC_ADDR_CFG, 8'h1B, "cfg_unused");
    wr(`SAC_ADDR_PORTMODE, 8'h5A);
    wr(`SAC_ADDR_CHAN, 8'hFF);
    wr(`SAC_ADDR_DATA, 8'h77);
    wr(8'h00, 8'h55);
    @(negedge clk);
    chk("pin_mask", 16'h00A5, {8'h00, analogPinMask});
    chk("mux", 16'h0007, {13'h0000, muxChannel});
    rd(`SAC_ADDR_CHAN, 8'h07, "chan_unused");
    rd(`SAC_ADDR_DATA, 8'h00, "data_ro");
    rd(8'h00, 8'h00, "unmapped");
  endtask : reset_and_regs

  task automatic conv(input logic [2:0] cm, input logic tm, input logic [4:0] dv, input logic [2:0] ch);
    int n;
    int lat;
    lat = (tm && cm != 3'h2 ? 11 : 8) * (dv + 1) + (cm == 3'h2 ? 5 : 2);
    wr(`SAC_ADDR_CHAN, {5'h00, ch});
    wr(`SAC_ADDR_CFG, {dv, 3'h0});
    wr(`SAC_ADDR_CTRL, {1'b1, tm, 2'b00, cm, 1'b0});
    repeat (2) @(negedge clk);
    chk("track_idle", {15'h0000, !tm || cm == 3'h2}, {15'h0000, trackEnable});
    @(posedge clk);
    case (cm)
      3'h0: begin
        regAddr <= `SAC_ADDR_CTRL;
        regWrData <= {1'b1, tm, 2'b01, cm, 1'b0};
        regWr <= 1'b1;
      end
      3'h1: timer3Overflow <= 1'b1;
      3'h2: extConvStartPin <= 1'b1;
      3'h3: timer2Overflow <= 1'b1;
      default: companionStartWrite <= 1'b1;
    endcase
    @(posedge clk);
    regWr <= 1'b0;
    timer3Overflow <= 1'b0;
    timer2Overflow <= 1'b0;
    companionStartWrite <= 1'b0;
    n = 1;
    @(negedge clk);
    while (convIrq !== 1'b1 && n < 400) begin
      if (n == 6 && !tm) chk("track_conv", 16'h0000, {15'h0000, trackEnable});
      @(posedge clk);
      timer3Overflow <= (n == 2);
      companionStartWrite <= (n == 2);
      n++;
      @(negedge clk);
    end
    if (n == 400) begin
      err_count++;
      $display("ERROR conv_done expected irq seen none");
      stop_test();
    end
    chk("latency", lat[15:0], n[15:0]);
    @(negedge clk);
    chk("irq_pulse", 16'h0000, {15'h0000, convIrq});
    chk("trial_idle", 16'h0080, {8'h00, sarTrialCode});
    @(posedge clk);
    extConvStartPin <= 1'b0;
    rd(`SAC_ADDR_DATA, 8'h11 + 8'h1F * {5'h00, ch}, "result");
    rd(`SAC_ADDR_CTRL, {1'b1, tm, 2'b10, cm, 1'b0}, "flag_set");
    rd(`SAC_ADDR_CTRL, {1'b1, tm, 2'b10, cm, 1'b0}, "flag_kept");
    wr(`SAC_ADDR_CTRL, {1'b1, tm, 2'b00, cm, 1'b0});
  endtask : conv

  task automatic abort_and_quiet();
    int seen;
    seen = 0;
    irqEnable <= 1'b0;
    wr(`SAC_ADDR_CFG, 8'h18);
    wr(`SAC_ADDR_CTRL, 8'h90);
    repeat (40) @(negedge clk) seen |= convIrq;
    chk("irq_masked", 16'h0000, seen[15:0]);
    rd(`SAC_ADDR_CTRL, 8'hA0, "poll_flag");
    @(posedge clk);
    irqEnable <= 1'b1;
    wr(`SAC_ADDR_CFG, 8'hF8);
    wr(`SAC_ADDR_CTRL, 8'h90);
    repeat (20) @(posedge clk);
    wr(`SAC_ADDR_CTRL, 8'h00);
    repeat (300) @(negedge clk) seen |= convIrq;
    chk("abort_irq", 16'h0000, seen[15:0]);
    chk("power_off", 16'h0000, {14'h0000, converterPowerOn, trackEnable});
    rd(`SAC_ADDR_CTRL, 8'h00, "abort_flag");
  endtask : abort_and_quiet

  task automatic standby();
    wr(`SAC_ADDR_CTRL, 8'h80);
    repeat (2) @(negedge clk);
    chk("track_on", 16'h0003, {14'h0000, converterPowerOn, trackEnable});
    @(posedge clk);
    chipStandby <= 1'b1;
    repeat (2) @(negedge clk);
    chk("track_standby", 16'h0000, {15'h0000, trackEnable});
    @(posedge clk);
    chipStandby <= 1'b0;
  endtask : standby

  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reset_and_regs();
    for (i = 0; i < 8; i++) conv(3'h0, 1'b0, 5'h03, i[2:0]);
    conv(3'h1, 1'b0, 5'h04, 3'h3);
    conv(3'h3, 1'b1, 5'h03, 3'h6);
    conv(3'h4, 1'b1, 5'h05, 3'h1);
    conv(3'h7, 1'b0, 5'h1F, 3'h5);
    conv(3'h2, 1'b1, 5'h03, 3'h2);
    conv(3'h2, 1'b0, 5'h06, 3'h4);
    abort_and_quiet();
    standby();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("ERROR run_length expected end seen timeout");
    stop_test();
  end
endmodule : tb
